//--- design/trace_seq_pkg.sv
// Shared constants for the trace sequencer: register map, field layout,
// command and condition codes, reset values.
// Assumes a 32-bit AHB-Lite register bus and 14 decoded address bits.
package trace_seq_pkg;
  localparam logic [13:0] CTRL_OFF = 14'h0000;
  localparam logic [13:0] STAT_OFF = 14'h0004;
  localparam logic [13:0] WCNT_OFF = 14'h0008;
  localparam logic [13:0] HOLD_OFF = 14'h0010;
  localparam logic [13:0] HOLD_END = 14'h0028;
  // Level words at 0x0400 + 4*level, command words at 0x0800 + 0x80*level + 0x20*cmd + 4*field
  localparam logic [3:0] LVL_PAGE = 4'h1;
  localparam logic [2:0] CMD_PAGE = 3'h1;
  localparam logic [1:0] MEM_LO_PAGE = 2'h1;
  localparam logic [1:0] MEM_HI_PAGE = 2'h2;
  localparam logic [2:0] F_PAT_LO = 3'h0;
  localparam logic [2:0] F_PAT_HI = 3'h1;
  localparam logic [2:0] F_CARE_LO = 3'h2;
  localparam logic [2:0] F_CARE_HI = 3'h3;
  localparam logic [2:0] F_COND = 3'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int LVL_PCNT_BIT = 16;
  localparam int LVL_TGT_LSB = 20;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] DLY_RST = 16'h0000;
  typedef enum logic [1:0] {CMD_HALT = 2'h0, CMD_JUMP = 2'h1, CMD_STEP = 2'h2, CMD_STORE = 2'h3} cmd_e;
  typedef enum logic [3:0] {
    C_MATCH = 4'h0, C_ALWAYS = 4'h1, C_NEVER = 4'h2, C_GT = 4'h3, C_LT = 4'h4,
    C_EQ = 4'h5, C_GE = 4'h6, C_LE = 4'h7, C_NE = 4'h8
  } cond_e;
  typedef enum logic [1:0] {CK_INT = 2'h0, CK_SGL = 2'h1, CK_MULTI = 2'h2} clk_mode_e;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_HALT = 2'h2} run_e;
  localparam logic [1:0] MODE_RST = CK_INT;
endpackage : trace_seq_pkg

//--- design/acq_mem.sv
// Acquisition memory: one write port, one read port with registered data.
// Assumes write and read addresses are in range.
`timescale 1ns/100ps
`default_nettype none
module acq_mem #(
  parameter int W = 48,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : acq_mem
`default_nettype wire

//--- design/trace_sequencer.sv
// Trace sequencer: synchronises probe data and clocks, walks the level
// program per sample and writes chosen samples into acquisition memory.
// Assumes probe pins and external clocks are asynchronous to clk.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module trace_sequencer import trace_seq_pkg::*; #(
  parameter int SEC_W = 16,
  parameter int NSEC = 3,
  parameter int DEPTH = 512,
  parameter int LEVELS = 16,
  parameter int INT_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [SEC_W*NSEC-1:0] probe_in,
  input wire logic master_clk_in,
  input wire logic [NSEC-1:0] sec_clk_in,
  output logic [3:0] active_level,
  output logic recording,
  output logic mem_full
);
  localparam int W = SEC_W * NSEC;
  localparam int AW = $clog2(DEPTH);

  // Pin synchronisers; third clock stage only feeds edge detection
  logic [W-1:0] pin_m, pin_s;
  logic [NSEC:0] ck_m, ck_s, ck_d;
  logic [7:0] div_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= '0;
      pin_s <= '0;
      ck_m <= '0;
      ck_s <= '0;
      ck_d <= '0;
      div_r <= '0;
    end else begin
      pin_m <= probe_in;
      pin_s <= pin_m;
      ck_m <= {sec_clk_in, master_clk_in};
      ck_s <= ck_m;
      ck_d <= ck_s;
      div_r <= (div_r == 8'(INT_DIV - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end
  wire [NSEC:0] ck_rise = ck_s & ~ck_d;
  wire int_tick = (div_r == 8'(INT_DIV - 1));

  logic [1:0] mode_r;
  logic [W-1:0] sec_r, s_r;
  logic s_v;
  wire [W-1:0] sec_now;
  for (genvar g = 0; g < NSEC; g++) begin : g_sec
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sec_r[g*SEC_W +: SEC_W] <= '0;
      end else if (mode_r == CK_MULTI && ck_rise[g+1]) begin
        sec_r[g*SEC_W +: SEC_W] <= pin_s[g*SEC_W +: SEC_W];
      end
    end
    // Section clocked on the master edge bypasses its latch, else it lags one sample
    assign sec_now[g*SEC_W +: SEC_W] = ck_rise[g+1] ? pin_s[g*SEC_W +: SEC_W] : sec_r[g*SEC_W +: SEC_W];
  end
  wire samp_fire = (mode_r == CK_INT) ? int_tick : ck_rise[0];
  wire [W-1:0] samp_word = (mode_r == CK_MULTI) ? sec_now : pin_s;

  logic [W-1:0] hold_r [3];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_v <= 1'b0;
      hold_r <= '{default: '0};
    end else begin
      s_v <= samp_fire;
      if (samp_fire) begin
        s_r <= samp_word;
      end
      if (s_v) begin
        hold_r[0] <= s_r;
        hold_r[1] <= hold_r[0];
        hold_r[2] <= hold_r[1];
      end
    end
  end

  // Bus front end: reads take one wait state, writes none
  logic wr_pend_r, rd_pend_r;
  logic [13:0] a_r;
  wire acc = hsel && htrans[1] && hready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      a_r <= '0;
    end else begin
      wr_pend_r <= acc && hwrite;
      rd_pend_r <= acc && !hwrite;
      if (acc) begin
        a_r <= haddr[13:0];
      end
    end
  end
  assign hreadyout = !rd_pend_r;
  assign hresp = 1'b0;

  function automatic logic is_cmd(input logic [13:0] a);
    return a[13:11] == CMD_PAGE;
  endfunction : is_cmd

  function automatic logic cond_true(input logic [3:0] c, input logic m, input logic [15:0] n,
                                     input logic [15:0] d);
    case (c)
      C_MATCH: return m;
      C_ALWAYS: return 1'b1;
      C_NEVER: return 1'b0;
      C_GT: return m && (n > d);
      C_LT: return m && (n < d);
      C_EQ: return m && (n == d);
      C_GE: return m && (n >= d);
      C_LE: return m && (n <= d);
      C_NE: return m && (n != d);
      default: return 1'b0;
    endcase
  endfunction : cond_true

  wire cmd_wr = wr_pend_r && is_cmd(a_r);
  wire lvl_wr = wr_pend_r && a_r[13:10] == LVL_PAGE;
  wire ctrl_wr = wr_pend_r && a_r == CTRL_OFF;
  wire start = ctrl_wr && hwdata[CTRL_START_BIT];
  wire [2:0] wa_fld = a_r[4:2];

  logic [63:0] pat_r [LEVELS][4];
  logic [63:0] care_r [LEVELS][4];
  logic [3:0] cond_r [LEVELS][4];
  logic [15:0] dly_r [LEVELS];
  logic pcnt_r [LEVELS];
  logic [3:0] tgt_r [LEVELS];

  // independent program per command; sixteen levels
  for (genvar gl = 0; gl < LEVELS; gl++) begin : g_lvl
    for (genvar gc = 0; gc < 4; gc++) begin : g_cmd
      wire hit = cmd_wr && a_r[10:7] == 4'(gl) && a_r[6:5] == 2'(gc);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pat_r[gl][gc] <= '0;
          care_r[gl][gc] <= '0;
          cond_r[gl][gc] <= C_NEVER;
        end else if (hit) begin
          case (wa_fld)
            F_PAT_LO: pat_r[gl][gc][31:0] <= hwdata;
            F_PAT_HI: pat_r[gl][gc][63:32] <= hwdata;
            F_CARE_LO: care_r[gl][gc][31:0] <= hwdata;
            F_CARE_HI: care_r[gl][gc][63:32] <= hwdata;
            F_COND: cond_r[gl][gc] <= hwdata[3:0];
            default: ;
          endcase
        end
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        dly_r[gl] <= DLY_RST;
        pcnt_r[gl] <= 1'b0;
        tgt_r[gl] <= '0;
      end else if (lvl_wr && a_r[5:2] == 4'(gl)) begin
        dly_r[gl] <= hwdata[15:0];
        pcnt_r[gl] <= hwdata[LVL_PCNT_BIT];
        tgt_r[gl] <= hwdata[LVL_TGT_LSB +: 4];
      end
    end
  end

  run_e state_r, state_nxt;
  logic [3:0] lvl_r, lvl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [AW:0] wptr_r, wptr_nxt;
  logic [3:0] hit_m, cmd_t;

  // count samples or step-pattern hits, this sample included
  wire inc = pcnt_r[lvl_r] ? hit_m[CMD_STEP] : 1'b1;
  wire [15:0] cnt_now = (cnt_r == CNT_MAX || !inc) ? cnt_r : cnt_r + 16'h0001;

  for (genvar gc = 0; gc < 4; gc++) begin : g_eval
    // own pattern; care bit zero means don't-care
    assign hit_m[gc] = ((s_r ^ pat_r[lvl_r][gc][W-1:0]) & care_r[lvl_r][gc][W-1:0]) == '0;
    assign cmd_t[gc] = cond_true(cond_r[lvl_r][gc], hit_m[gc], cnt_now, dly_r[lvl_r]);
  end

  wire go = s_v && state_r == ST_RUN;
  // store on its own condition only
  wire we = go && cmd_t[CMD_STORE] && !mem_full;
  wire last_w = we && wptr_r == (AW+1)'(DEPTH - 1);
  // halt outranks jump; full memory ends recording
  wire halt_now = go && (cmd_t[CMD_HALT] || last_w);
  wire jump_now = go && !cmd_t[CMD_HALT] && cmd_t[CMD_JUMP];
  wire step_now = go && !cmd_t[CMD_HALT] && !cmd_t[CMD_JUMP] && cmd_t[CMD_STEP];
  wire [3:0] step_lvl = (lvl_r == 4'(LEVELS - 1)) ? 4'h0 : lvl_r + 4'h1;

  // halted state left only by restart
  assign state_nxt = start ? ST_RUN : halt_now ? ST_HALT : state_r;
  assign lvl_nxt = start ? 4'h0 : jump_now ? tgt_r[lvl_r] : step_now ? step_lvl : lvl_r;
  assign cnt_nxt = start || jump_now || step_now ? 16'h0000 : (go && !halt_now) ? cnt_now : cnt_r;
  assign wptr_nxt = start ? '0 : we ? wptr_r + (AW+1)'(1) : wptr_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      lvl_r <= 4'h0;
      cnt_r <= 16'h0000;
      wptr_r <= '0;
      mode_r <= MODE_RST;
    end else begin
      state_r <= state_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      wptr_r <= wptr_nxt;
      if (ctrl_wr) begin
        mode_r <= hwdata[CTRL_MODE_LSB +: 2];
      end
    end
  end
  assign active_level = lvl_r;
  assign recording = state_r == ST_RUN;
  assign mem_full = wptr_r == (AW+1)'(DEPTH);

  // store uses the level still active on this sample
  logic [W-1:0] mem_rdata;
  acq_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(we),
    .waddr(wptr_r[AW-1:0]),
    .wdata(s_r),
    .raddr(haddr[AW+1:2]),
    .rdata(mem_rdata)
  );

  // Read mux, sampled in the wait cycle
  wire [63:0] mem64 = 64'(mem_rdata);
  wire [13:0] ho = a_r - HOLD_OFF;
  wire hold_hit = a_r >= HOLD_OFF && a_r < HOLD_END;
  wire [63:0] hold64 = 64'(hold_r[ho[4:3] == 2'h3 ? 2'h0 : ho[4:3]]);
  wire [31:0] hold_w = ho[2] ? hold64[63:32] : hold64[31:0];
  wire [31:0] stat_w = {cnt_r, 8'h00, lvl_r, 2'h0, mem_full, recording};
  wire [31:0] reg_w = (a_r == CTRL_OFF) ? {29'h0, mode_r, 1'b0} :
                      (a_r == STAT_OFF) ? stat_w :
                      (a_r == WCNT_OFF) ? 32'(wptr_r) :
                      hold_hit ? hold_w : 32'h0000_0000;
  wire [31:0] rd_word = (a_r[13:12] == MEM_LO_PAGE) ? mem64[31:0] :
                        (a_r[13:12] == MEM_HI_PAGE) ? mem64[63:32] : reg_w;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata <= rd_word;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_store_step;
    go && cmd_t[CMD_STORE] && !mem_full && !cmd_t[CMD_HALT] && !cmd_t[CMD_JUMP] && cmd_t[CMD_STEP];
  endsequence
  sequence seq_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_store_indep: assert property (go && cmd_t[CMD_STORE] && !mem_full && !start
    |=> wptr_r == $past(wptr_r) + (AW+1)'(1))
    else $error("store condition did not write");
  a_halt_wins: assert property (go && cmd_t[CMD_HALT] && cmd_t[CMD_JUMP] |=> state_r == ST_HALT)
    else $error("halt lost to jump");
  a_jump_wins: assert property (go && !cmd_t[CMD_HALT] && cmd_t[CMD_JUMP] && cmd_t[CMD_STEP]
    |=> lvl_r == $past(tgt_r[lvl_r]) && cnt_r == 16'h0000)
    else $error("jump not taken over step");
  a_store_then_step: assert property (seq_store_step |-> we ##1 lvl_r != $past(lvl_r, 1) || LEVELS == 1)
    else $error("store and step out of order");
  a_no_stray_write: assert property (we |-> s_v && state_r == ST_RUN)
    else $error("write outside a running sample");
  a_full_halts: assert property (we && wptr_r == (AW+1)'(DEPTH - 1) |=> state_r == ST_HALT && mem_full)
    else $error("full memory did not end recording");
  a_halt_holds: assert property (state_r == ST_HALT && !start |=> state_r == ST_HALT && !we)
    else $error("halted sequencer resumed");
  a_hold_shift: assert property (s_v |=> hold_r[0] == $past(s_r) && hold_r[1] == $past(hold_r[0]))
    else $error("holding registers did not shift");
  a_cnt_clock: assert property (go && !halt_now && !jump_now && !step_now && !pcnt_r[lvl_r]
    && cnt_r != CNT_MAX |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("sample count did not advance");
  a_multi_latch: assert property (mode_r == CK_MULTI && ck_rise[1] |=> sec_r[SEC_W-1:0] == $past(pin_s[SEC_W-1:0]))
    else $error("section not latched on its clock");
  a_read_wait: assert property (acc && !hwrite |=> seq_read_wait)
    else $error("read wait state wrong");
endmodule : trace_sequencer
`default_nettype wire

//--- testbench/probe_source.sv
// Target-system model: walking-ones probe byte, random upper probe bits.
// Assumes external single-phase sampling on the master clock pin.
`timescale 1ns/100ps
`default_nettype none
module probe_source (
  input wire logic clk,
  input wire logic run,
  input wire logic [31:0] rnd,
  output logic [47:0] probe_in,
  output logic master_clk_in,
  output logic tick,
  output logic [47:0] word
);
  int ph = 0;
  int idx = 0;
  initial begin
    probe_in = '0;
    master_clk_in = 1'b0;
    tick = 1'b0;
    word = '0;
  end
  // Data set up 3 cycles before the clock edge and held 5 after it; clock idles low between samples
  always @(posedge clk) begin
    tick <= 1'b0;
    ph <= (ph == 0 && !run) ? 0 : (ph + 1) % 8;
    if (ph == 0 && run) begin
      word = {rnd, 8'h00, 8'h01 << idx};
      idx = (idx + 1) % 8;
      probe_in <= word;
    end
    if (ph == 3) begin
      master_clk_in <= 1'b1;
      tick <= 1'b1;
    end
    if (ph == 6) master_clk_in <= 1'b0;
  end
endmodule : probe_source
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench: AHB-Lite programming, probe traffic, reference model.
// Assumes hready is looped back from hreadyout; section clocks follow the master pin.
`timescale 1ns/100ps
`default_nettype none
module tb_top import trace_seq_pkg::*;;
  localparam int DEPTH = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [31:0] rnd = '0;
  wire logic hreadyout, hresp, master_clk_in, recording, mem_full, tick;
  wire logic [31:0] hrdata;
  wire logic [47:0] probe_in, word;
  wire logic [3:0] active_level;
  int error_cnt = 0, comparisons = 0;
  int cnd[16][4], dly[16], tgt[16], lvl, rec, k;
  bit pc[16];
  logic [47:0] pat[16][4], care[16][4], q[$], em[$];

  always #2 clk = ~clk;
  always @(posedge clk) if (tick) q.push_back(word);

  trace_sequencer #(.DEPTH(DEPTH), .INT_DIV(2)) i_trace_sequencer (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .probe_in(probe_in), .master_clk_in(master_clk_in),
    .sec_clk_in({3{master_clk_in}}), .active_level(active_level), .recording(recording), .mem_full(mem_full));
  probe_source i_probe_source (.clk(clk), .run(run), .rnd(rnd), .probe_in(probe_in), .master_clk_in(master_clk_in),
    .tick(tick), .word(word));

  task automatic print_verdict;
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic waitrdy;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : waitrdy

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdchk

  task automatic cmd(input int l, input int c, input logic [47:0] p, input logic [47:0] m, input int cd);
    logic [31:0] b;
    b = 32'h800 + l * 32'h80 + c * 32'h20;
    pat[l][c] = p;
    care[l][c] = m;
    cnd[l][c] = cd;
    wr(b, p[31:0]);
    wr(b + 32'h4, {16'h0, p[47:32]});
    wr(b + 32'h8, m[31:0]);
    wr(b + 32'hC, {16'h0, m[47:32]});
    wr(b + 32'h10, 32'(cd));
  endtask : cmd

  task automatic lvlw(input int l, input int d, input int t, input bit p = 1'b0);
    dly[l] = d;
    tgt[l] = t;
    pc[l] = p;
    wr(32'h400 + 4 * l, 32'(d) | (32'(t) << LVL_TGT_LSB) | (32'(p) << LVL_PCNT_BIT));
  endtask : lvlw

  task automatic do_reset;
    rst_n <= 1'b0;
    foreach (cnd[l, c]) begin
      cnd[l][c] = 2;
      care[l][c] = '0;
      pat[l][c] = '0;
    end
    foreach (dly[l]) begin
      dly[l] = 0;
      tgt[l] = 0;
      pc[l] = 1'b0;
    end
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({26'h0, active_level, recording, mem_full}, 32'h0);
  endtask : do_reset

  function automatic bit hit(int l, int c, logic [47:0] w, int n);
    bit m;
    int d;
    m = ((w ^ pat[l][c]) & care[l][c]) === '0;
    d = dly[l];
    case (cnd[l][c])
      0: return m;
      1: return 1'b1;
      3: return m && n > d;
      4: return m && n < d;
      5: return m && n == d;
      6: return m && n >= d;
      7: return m && n <= d;
      8: return m && n != d;
      default: return 1'b0;
    endcase
  endfunction : hit

  task automatic go(input int ns, input logic [1:0] md = CK_SGL);
    bit h[4];
    int cnt;
    logic [31:0] r;
    q.delete();
    em.delete();
    wr(CTRL_OFF, (32'(md) << CTRL_MODE_LSB) | 32'h1);
    run <= 1'b1;
    while (q.size() < ns) begin
      rnd <= $urandom;
      @(posedge clk);
    end
    run <= 1'b0;
    repeat (24) @(posedge clk);
    lvl = 0;
    cnt = 0;
    rec = 1;
    foreach (q[i]) if (rec) begin
      if (cnt < 65535 && (!pc[lvl] || ((q[i] ^ pat[lvl][CMD_STEP]) & care[lvl][CMD_STEP]) === '0)) cnt++;
      foreach (h[c]) h[c] = hit(lvl, c, q[i], cnt);
      if (h[CMD_STORE]) em.push_back(q[i]);
      if (h[CMD_HALT]) rec = 0;
      else if (h[CMD_JUMP]) begin
        lvl = tgt[lvl];
        cnt = 0;
      end else if (h[CMD_STEP]) begin
        lvl = (lvl + 1) % 16;
        cnt = 0;
      end
      // Full memory halts, but the level change of that sample still lands
      if (em.size() == DEPTH) rec = 0;
    end
    chk({26'h0, active_level, recording, mem_full}, 32'({lvl[3:0], rec[0], em.size() == DEPTH}));
    bus(1'b0, {18'h0, STAT_OFF}, 32'h0, r);
    chk(r & 32'hFF, 32'({lvl[3:0], 2'b00, em.size() == DEPTH, rec[0]}));
    chk({31'h0, hresp}, 32'h0);
    rdchk({18'h0, WCNT_OFF}, em.size());
    foreach (em[i]) begin
      rdchk(32'h1000 + 4 * i, em[i][31:0]);
      rdchk(32'h2000 + 4 * i, {16'h0, em[i][47:32]});
    end
    foreach (q[i]) if (i + 3 >= q.size()) begin
      rdchk(HOLD_OFF + 8 * (q.size() - 1 - i), q[i][31:0]);
      rdchk(HOLD_OFF + 8 * (q.size() - 1 - i) + 4, {16'h0, q[i][47:32]});
    end
  endtask : go

  initial begin
    k = $urandom(32'h4f5d02f6);
    do_reset();
    cmd(0, CMD_STEP, 48'h1, 48'hFF, C_MATCH);
    cmd(0, CMD_STORE, 48'h0, 48'h0, C_ALWAYS);
    cmd(1, CMD_STEP, 48'h80, 48'hFF, C_MATCH);
    lvlw(2, 5, 0);
    cmd(2, CMD_HALT, 48'hFF, 48'h0, C_GT);
    cmd(2, CMD_STORE, 48'h0, 48'h0, C_ALWAYS);
    go(30);
    rdchk(32'h400, 32'h0);
    rdchk(32'hC, 32'h0);
    do_reset();
    cmd(0, CMD_STORE, 48'h1, 48'hFF, C_MATCH);
    go(8 * DEPTH + 8);
    // internal clock fills memory with the held probe word
    do_reset();
    cmd(0, CMD_STORE, 48'h0, 48'h0, C_ALWAYS);
    wr(CTRL_OFF, (32'(CK_INT) << CTRL_MODE_LSB) | 32'h1);
    repeat (8 * DEPTH) @(posedge clk);
    chk({26'h0, active_level, recording, mem_full}, 32'h1);
    rdchk({18'h0, WCNT_OFF}, DEPTH);
    rdchk(32'h1000 + 4 * (DEPTH - 1), word[31:0]);
    rdchk(HOLD_OFF + 16, word[31:0]);
    // multi-phase sampling, halt after two step-pattern hits
    do_reset();
    lvlw(0, 2, 0, 1'b1);
    cmd(0, CMD_STEP, 48'h1, 48'hFF, C_NEVER);
    cmd(0, CMD_HALT, 48'h0, 48'h0, C_GE);
    cmd(0, CMD_STORE, 48'h0, 48'h0, C_ALWAYS);
    go(24, CK_MULTI);
    rdchk(CTRL_OFF, 32'(CK_MULTI) << CTRL_MODE_LSB);
    // every store code with halt, jump and step contending
    for (int c = 0; c < 9; c++) begin
      do_reset();
      cmd(0, CMD_JUMP, 48'h4, 48'hFF, C_MATCH);
      cmd(0, CMD_STEP, 48'h4, 48'hFF, C_MATCH);
      lvlw(0, 0, 5);
      lvlw(5, $urandom_range(2), 5);
      cmd(5, CMD_HALT, 48'h80, 48'hFF, C_MATCH);
      cmd(5, CMD_JUMP, 48'h0, 48'h0, C_ALWAYS);
      cmd(5, CMD_STORE, 48'h20, 48'hFF, c);
      go(24);
    end
    print_verdict();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
